// >>> core/uhp_port.sv
// root-port power, suspend, resume and wake logic with apb registers
// assumes line-state inputs come from a phy in another domain and that
// the frame boundary pulse is on pclk
`include "uhp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Behaviour
// - power switch enable is capability and configured and port power
// - over-current active and change bits stay static, never wake
// - resume from remote-wakeup device is honoured and may wake system
// - per-port bits enable wake on connect and on disconnect
// - new suspend acted on no later than next frame boundary
// - forced resume set drives resume signaling downstream
// - writing zero ends resume, then clears forced resume and suspend
// - software resume sets no change detect and no interrupt
// - remote resume reflected in 100 us, sets resume and change detect
// - change detect with enable raises the interrupt
// - remote resume k on a disabled port has no effect; a forced resume write still starts resume
// - disconnect clears connect and enable, sets change bits
// - connect sets connect status, change, and change detect
// - reported over-current would set bits; not reported here
// - wake output needs feature enabled, plus matching enable for connect or disconnect
module uhp_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_boundary,
  input  wire logic        line_connect,
  input  wire logic        line_resume_k,
  input  wire logic        controller_halted,
  output logic             port_power_switch_enable,
  output logic             drive_resume_k,
  output logic             drive_eop,
  output logic             port_suspended,
  output logic             irq,
  output logic             power_mgmt_event_n
);
  logic        wr;
  logic        rd;
  logic        run;
  logic        configured_flag;
  logic        pme_feature_en;
  logic        pce;
  logic        pcd;
  logic        pme_status;
  logic        ccs;
  logic        csc;
  logic        pe;
  logic        fpr;
  logic        susp;
  logic        port_power_on;
  logic        wake_on_connect_en;
  logic        wake_on_disconnect_en;
  logic        wake_on_overcurrent_en;
  logic        susp_pending;
  logic        conn_s;
  logic        conn_d;
  logic        kres_s;
  logic        connect_ev;
  logic        disconn_ev;
  logic        remote_ev;
  logic        fpr_clear_wr;
  logic        fpr_set_wr;
  logic [15:0] cnt;
  logic [31:0] port_status_control_reg;
  uhp_pkg::uhp_state_e state;
  localparam logic [15:0] EOP_CYC     = 16'(`UHP_EOP_CYC);
  localparam logic        PWR_CAPABLE = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped offsets answer with pslverr
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  always_comb begin
    port_status_control_reg = 32'h0;
    port_status_control_reg[`UHP_PS_CCS]  = ccs;
    port_status_control_reg[`UHP_PS_CSC]  = csc;
    port_status_control_reg[`UHP_PS_PE]   = pe;
    port_status_control_reg[`UHP_PS_FPR]  = fpr;
    port_status_control_reg[`UHP_PS_SUSP] = susp;
    port_status_control_reg[`UHP_PS_PWR]  = port_power_on;
    port_status_control_reg[`UHP_PS_WKCN] = wake_on_connect_en;
    port_status_control_reg[`UHP_PS_WKDC] = wake_on_disconnect_en;
    port_status_control_reg[`UHP_PS_WKOC] = wake_on_overcurrent_en;
    // over-current is sensed off chip: both bits read zero always
    port_status_control_reg[`UHP_PS_OCA]  = 1'b0;
    port_status_control_reg[`UHP_PS_OCC]  = 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (rd) begin
      pslverr <= 1'b0;
      case (paddr)
        `UHP_OFS_CMD:    prdata <= {31'h0, run};
        `UHP_OFS_STS:    prdata <= {15'h0, pme_status, 3'h0,
                                    controller_halted, 9'h0, pcd, 2'h0};
        `UHP_OFS_INTR:   prdata <= {29'h0, pce, 2'h0};
        `UHP_OFS_CFG:    prdata <= {30'h0, pme_feature_en, configured_flag};
        `UHP_OFS_PARAMS: prdata <= {27'h0, PWR_CAPABLE, 4'h1};
        `UHP_OFS_PORT:   prdata <= port_status_control_reg;
        default: begin
          prdata  <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      pslverr <= !(paddr inside {`UHP_OFS_CMD, `UHP_OFS_STS, `UHP_OFS_INTR,
                    `UHP_OFS_CFG, `UHP_OFS_PARAMS, `UHP_OFS_PORT});
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run             <= 1'b0;
      pce             <= 1'b0;
      configured_flag <= 1'b0;
      pme_feature_en  <= 1'b0;
    end else if (wr) begin
      if (paddr == `UHP_OFS_CMD) run <= pwdata[`UHP_CMD_RUN];
      if (paddr == `UHP_OFS_INTR) pce <= pwdata[`UHP_INTR_PCE];
      if (paddr == `UHP_OFS_CFG) begin
        configured_flag <= pwdata[`UHP_CFG_CONF];
        pme_feature_en  <= pwdata[`UHP_CFG_PMEEN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line state crossing
  uhp_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({line_connect, line_resume_k}),
    .q       ({conn_s, kres_s})
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) conn_d <= 1'b0;
    else          conn_d <= conn_s;
  end
  assign connect_ev = conn_s && !conn_d && !ccs;
  assign disconn_ev = !conn_s && conn_d && ccs;
  // resume k only counts on a suspended port; disabled port ignores it
  assign remote_ev  = kres_s && (state == uhp_pkg::UHP_SUSPEND) && pe;
  assign fpr_set_wr = wr && (paddr == `UHP_OFS_PORT) && pwdata[`UHP_PS_FPR];
  assign fpr_clear_wr = wr && (paddr == `UHP_OFS_PORT) && fpr
                        && !pwdata[`UHP_PS_FPR];
  ////////////////////////////////////////////////////////////////////////
  // port control and status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_power_on          <= 1'b0;
      wake_on_connect_en     <= 1'b0;
      wake_on_disconnect_en  <= 1'b0;
      wake_on_overcurrent_en <= 1'b0;
      pe                     <= 1'b0;
    end else begin
      if (wr && paddr == `UHP_OFS_PORT) begin
        port_power_on          <= pwdata[`UHP_PS_PWR];
        wake_on_connect_en     <= pwdata[`UHP_PS_WKCN];
        wake_on_disconnect_en  <= pwdata[`UHP_PS_WKDC];
        wake_on_overcurrent_en <= pwdata[`UHP_PS_WKOC];
        // software may only disable; enable comes from a connect event
        if (!pwdata[`UHP_PS_PE]) pe <= 1'b0;
      end
      if (connect_ev) pe <= 1'b1;
      if (disconn_ev) pe <= 1'b0;
    end
  end
  // connect status and its change bit; hardware set beats write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccs <= 1'b0;
      csc <= 1'b0;
    end else begin
      if (wr && paddr == `UHP_OFS_PORT && pwdata[`UHP_PS_CSC]) csc <= 1'b0;
      if (connect_ev) begin
        ccs <= 1'b1;
        csc <= 1'b1;
      end
      if (disconn_ev) begin
        ccs <= 1'b0;
        csc <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // suspend / resume sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= uhp_pkg::UHP_ACTIVE;
      susp         <= 1'b0;
      susp_pending <= 1'b0;
      fpr          <= 1'b0;
      cnt          <= 16'h0;
    end else begin
      case (state)
        uhp_pkg::UHP_ACTIVE: begin
          if (wr && paddr == `UHP_OFS_PORT && pwdata[`UHP_PS_SUSP] && pe) begin
            susp         <= 1'b1;
            susp_pending <= 1'b1;
          end
          // suspend takes hold at the next frame boundary
          if ((susp_pending || susp) && frame_boundary) begin
            susp_pending <= 1'b0;
            state        <= uhp_pkg::UHP_SUSPEND;
          end
        end
        uhp_pkg::UHP_SUSPEND: begin
          cnt <= 16'h0;
          if (fpr_set_wr) begin
            fpr   <= 1'b1;
            state <= uhp_pkg::UHP_RESUME;
          end else if (remote_ev) begin
            fpr   <= 1'b1;
            state <= uhp_pkg::UHP_RESUME;
          end
        end
        uhp_pkg::UHP_RESUME: begin
          if (fpr_clear_wr) begin
            cnt   <= 16'h0;
            state <= uhp_pkg::UHP_EOP;
          end
        end
        uhp_pkg::UHP_EOP: begin
          cnt <= cnt + 16'h1;
          if (cnt == EOP_CYC - 16'h1) begin
            fpr   <= 1'b0;
            susp  <= 1'b0;
            state <= uhp_pkg::UHP_ACTIVE;
          end
        end
        default: state <= uhp_pkg::UHP_ACTIVE;
      endcase
      if (disconn_ev) begin
        state        <= uhp_pkg::UHP_ACTIVE;
        susp         <= 1'b0;
        susp_pending <= 1'b0;
        fpr          <= 1'b0;
      end
    end
  end
  // resume k driven combinationally from state: reflection is immediate
  assign drive_resume_k = (state == uhp_pkg::UHP_RESUME);
  assign drive_eop      = (state == uhp_pkg::UHP_EOP);
  assign port_suspended = (state == uhp_pkg::UHP_SUSPEND);
  assign port_power_switch_enable = PWR_CAPABLE && configured_flag
                                    && port_power_on;
  ////////////////////////////////////////////////////////////////////////
  // change detect, interrupt and power management event
  // only hardware events set it; software resume never does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcd <= 1'b0;
    end else if (remote_ev || connect_ev || disconn_ev) begin
      pcd <= 1'b1;
    end else if (wr && paddr == `UHP_OFS_STS && pwdata[`UHP_STS_PCD]) begin
      pcd <= 1'b0;
    end
  end
  assign irq = pcd && pce;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pme_status <= 1'b0;
    end else if (remote_ev || connect_ev || disconn_ev) begin
      pme_status <= 1'b1;
    end else if (wr && paddr == `UHP_OFS_STS && pwdata[`UHP_STS_PME]) begin
      pme_status <= 1'b0;
    end
  end
  // over-current is never reported, so it never reaches this output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mgmt_event_n <= 1'b1;
    end else if (pme_feature_en &&
                 (remote_ev || (connect_ev && wake_on_connect_en)
                  || (disconn_ev && wake_on_disconnect_en))) begin
      power_mgmt_event_n <= 1'b0;
    end else if (!pme_status) begin
      power_mgmt_event_n <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  chk_switch_enable: assert property (@(posedge pclk) disable iff (!presetn)
    port_power_switch_enable == (configured_flag && port_power_on))
    else $error("power switch enable mismatch");
  chk_oc_static: assert property (@(posedge pclk) disable iff (!presetn)
    port_status_control_reg[`UHP_PS_OCA] == 1'b0
    && port_status_control_reg[`UHP_PS_OCC] == 1'b0)
    else $error("over-current bits moved");
  chk_remote_reflect: assert property (@(posedge pclk) disable iff (!presetn)
    remote_ev && !disconn_ev |=> drive_resume_k && fpr && pcd)
    else $error("remote resume not reflected");
  chk_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
    pcd && pce |-> irq)
    else $error("interrupt missing");
  chk_sw_no_pcd: assert property (@(posedge pclk) disable iff (!presetn)
    fpr_set_wr && !remote_ev && !connect_ev && !disconn_ev && !pcd
    |=> !pcd)
    else $error("software resume set change detect");
  chk_disabled_k: assert property (@(posedge pclk) disable iff (!presetn)
    !pe && state == uhp_pkg::UHP_SUSPEND && !fpr_set_wr |=> !fpr)
    else $error("disabled port took resume");
  chk_resume_end: assert property (@(posedge pclk) disable iff (!presetn)
    state == uhp_pkg::UHP_RESUME && fpr_clear_wr && !disconn_ev
    |=> drive_eop ##[1:400] (!fpr && !susp))
    else $error("resume sequence did not end");
  chk_suspend_frame: assert property (@(posedge pclk) disable iff (!presetn)
    state == uhp_pkg::UHP_ACTIVE && susp && frame_boundary && !disconn_ev
    |=> port_suspended)
    else $error("suspend missed frame boundary");
  chk_connect_set: assert property (@(posedge pclk) disable iff (!presetn)
    connect_ev |=> ccs && csc && pcd)
    else $error("connect not recorded");
  chk_pme_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(power_mgmt_event_n) |-> $past(pme_feature_en))
    else $error("wake output without feature enable");
endmodule
`default_nettype wire

// >>> core/uhp_cfg.svh
// constants for the root-port suspend and wake block
// assumes inclusion by bare name from core/ sources
`ifndef UHP_CFG_SVH
`define UHP_CFG_SVH
// register byte offsets on apb
`define UHP_OFS_CMD      12'h000
`define UHP_OFS_STS      12'h004
`define UHP_OFS_INTR     12'h008
`define UHP_OFS_CFG      12'h00C
`define UHP_OFS_PARAMS   12'h010
`define UHP_OFS_PORT     12'h014
// command register fields
`define UHP_CMD_RUN      0
// status register fields
`define UHP_STS_PCD      2
`define UHP_STS_HALT     12
`define UHP_STS_PME      16
// interrupt enable fields
`define UHP_INTR_PCE     2
// structural parameter fields
`define UHP_PAR_PWR_CAP  4
// port status and control fields
`define UHP_PS_CCS       0
`define UHP_PS_CSC       1
`define UHP_PS_PE        2
`define UHP_PS_OCA       4
`define UHP_PS_OCC       5
`define UHP_PS_FPR       6
`define UHP_PS_SUSP      7
`define UHP_PS_PWR       12
`define UHP_PS_WKCN      20
`define UHP_PS_WKDC      21
`define UHP_PS_WKOC      22
// configured flag and global wake feature enable in config register
`define UHP_CFG_CONF     0
`define UHP_CFG_PMEEN    1
// timing: reflect resume within 100 us; end sequence low-speed eop
`define UHP_REFLECT_NS   100000
`define UHP_CLK_NS       5
`define UHP_REFLECT_CYC  ((`UHP_REFLECT_NS) / (`UHP_CLK_NS))
`define UHP_EOP_NS       1500
`define UHP_EOP_CYC      ((`UHP_EOP_NS + `UHP_CLK_NS - 1) / (`UHP_CLK_NS))
`endif

// >>> core/uhp_pkg.sv
// types for the root-port suspend and wake block
// assumes nothing beyond a systemverilog compiler
package uhp_pkg;
  typedef enum logic [3:0] {
    UHP_ACTIVE  = 4'h1,
    UHP_SUSPEND = 4'h2,
    UHP_RESUME  = 4'h4,
    UHP_EOP     = 4'h8
  } uhp_state_e;
endpackage

// >>> core/uhp_sync.sv
// two-flop synchroniser per bit
// assumes inputs are asynchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module uhp_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // first stage is read only by the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i] <= 1'b0;
          q[i]    <= 1'b0;
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> bench/uhp_dev_model.sv
// behavioural usb device on the root port: attach level and remote wake
// assumes the bench raises its requests on pclk edges
`timescale 1ns/10ps
`default_nettype none
module uhp_dev_model #(
  parameter int K_CYC = 12
) (
  input  wire logic pclk,
  input  wire logic attach,
  input  wire logic wake_req,
  output logic      line_connect,
  output logic      line_resume_k
);
  int k_left = 0;
  assign line_connect = attach;
  // remote wake holds k for a fixed span; kept short so it has ended
  // before the host finishes its own resume
  always @(posedge pclk) begin
    if (wake_req && attach)
      k_left <= K_CYC;
    else if (k_left > 0)
      k_left <= k_left - 1;
  end
  // released line returns to idle, never a stale k
  assign line_resume_k = (k_left > 0) && attach;
endmodule
`default_nettype wire

// >>> bench/usb_host_port_suspend_wake_bench.sv
// self-checking bench for the root-port suspend and wake block
// assumes uhp_cfg.svh on the include path and uhp_dev_model beside it
`timescale 1ns/10ps
`default_nettype none
`include "uhp_cfg.svh"
module usb_host_port_suspend_wake_bench;
  localparam logic [31:0] CSC  = 32'h1 << `UHP_PS_CSC;
  localparam logic [31:0] PE   = 32'h1 << `UHP_PS_PE;
  localparam logic [31:0] FPR  = 32'h1 << `UHP_PS_FPR;
  localparam logic [31:0] SUS  = 32'h1 << `UHP_PS_SUSP;
  localparam logic [31:0] PCD  = 32'h1 << `UHP_STS_PCD;
  localparam logic [31:0] PME  = 32'h1 << `UHP_STS_PME;
  localparam logic [31:0] PWR  = 32'h1 << `UHP_PS_PWR;
  localparam logic [31:0] WCN  = 32'h1 << `UHP_PS_WKCN;
  localparam logic [31:0] WDC  = 32'h1 << `UHP_PS_WKDC;
  localparam logic [31:0] BASE = PWR | WCN;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        frame_boundary, controller_halted, attach, wake_req;
  logic        line_connect, line_resume_k, port_power_switch_enable;
  logic        drive_resume_k, drive_eop, port_suspended, irq;
  logic        power_mgmt_event_n, perr;
  int          err_count, cmp_count;
  ////////////////////////////////////////////////////////////////////////
  uhp_port uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_boundary, .line_connect, .line_resume_k,
    .controller_halted, .port_power_switch_enable, .drive_resume_k,
    .drive_eop, .port_suspended, .irq, .power_mgmt_event_n
  );
  uhp_dev_model dev (.pclk, .attach, .wake_req, .line_connect,
                     .line_resume_k);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no limit here: only the watchdog ends a stalled transfer
    while (pready !== 1'b1)
      @(posedge pclk);
    rd   = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] mask,
                       input logic [31:0] exp, input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd & mask, exp, m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic boundary;
    @(posedge pclk);
    frame_boundary <= 1'b1;
    @(posedge pclk);
    frame_boundary <= 1'b0;
    tick(2);
  endtask
  task automatic remote_k;
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    tick(10);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(`UHP_OFS_PARAMS, 32'h1F, 32'h11, "params");
    rdchk(`UHP_OFS_STS, PCD | PME | 32'h1000, 32'h1000, "sts reset");
    rdchk(`UHP_OFS_PORT, 32'h30, 32'h0, "oc bits");
    rdchk(12'h020, 32'hFFFFFFFF, 32'h0, "unmapped data");
    chk(32'(perr), 32'h1, "unmapped err");
    chk(32'(power_mgmt_event_n), 32'h1, "wake idle");
    chk(32'(pready), 32'h1, "ready");
  endtask
  task automatic t_power;
    xfer(1'b1, `UHP_OFS_CFG, 32'h3);
    xfer(1'b1, `UHP_OFS_PORT, BASE);
    tick(1);
    chk(32'(port_power_switch_enable), 32'h1, "pwr on");
    xfer(1'b1, `UHP_OFS_PORT, WCN);
    tick(1);
    chk(32'(port_power_switch_enable), 32'h0, "pwr bit off");
    xfer(1'b1, `UHP_OFS_CFG, 32'h2);
    xfer(1'b1, `UHP_OFS_PORT, BASE);
    tick(1);
    chk(32'(port_power_switch_enable), 32'h0, "pwr cfg off");
    xfer(1'b1, `UHP_OFS_CFG, 32'h3);
  endtask
  task automatic t_connect;
    xfer(1'b1, `UHP_OFS_INTR, 32'h4);
    @(posedge pclk);
    attach <= 1'b1;
    tick(10);
    rdchk(`UHP_OFS_PORT, 32'h37, 32'h7, "conn bits");
    rdchk(`UHP_OFS_STS, PCD | PME, PCD | PME, "conn sts");
    chk(32'(irq), 32'h1, "conn irq");
    chk(32'(power_mgmt_event_n), 32'h0, "conn wake");
    xfer(1'b1, `UHP_OFS_STS, PCD | PME);
    xfer(1'b1, `UHP_OFS_PORT, BASE | PE | CSC);
    tick(1);
    chk(32'(irq), 32'h0, "irq clear");
    chk(32'(power_mgmt_event_n), 32'h1, "wake clear");
    rdchk(`UHP_OFS_PORT, CSC, 32'h0, "csc clear");
  endtask
  task automatic end_resume;
    int n;
    n = 0;
    xfer(1'b1, `UHP_OFS_CMD, 32'h1);
    @(posedge pclk);
    controller_halted <= 1'b0;
    rdchk(`UHP_OFS_STS, 32'h1000, 32'h0, "running");
    xfer(1'b1, `UHP_OFS_PORT, BASE | PE | SUS);
    while (drive_eop !== 1'b1 && n < 20) begin
      n++;
      tick(1);
    end
    chk(32'(drive_eop), 32'h1, "eop start");
    n = 0;
    while (drive_eop !== 1'b0 && n < 400) begin
      n++;
      tick(1);
    end
    tick(2);
    rdchk(`UHP_OFS_PORT, FPR | SUS | PE, PE, "resume end");
    chk(32'(drive_resume_k), 32'h0, "k off");
  endtask
  task automatic suspend;
    xfer(1'b1, `UHP_OFS_PORT, BASE | PE | SUS);
    boundary();
    chk(32'(port_suspended), 32'h1, "suspended");
  endtask
  task automatic t_sw_resume;
    suspend();
    tick(20);
    xfer(1'b1, `UHP_OFS_CMD, 32'h0);
    @(posedge pclk);
    controller_halted <= 1'b1;
    xfer(1'b1, `UHP_OFS_PORT, BASE | PE | SUS | FPR);
    tick(2);
    chk(32'(drive_resume_k), 32'h1, "sw k");
    rdchk(`UHP_OFS_STS, PCD, 32'h0, "sw no pcd");
    chk(32'(irq), 32'h0, "sw no irq");
    tick(20);
    end_resume();
  endtask
  task automatic t_remote;
    suspend();
    remote_k();
    chk(32'(drive_resume_k), 32'h1, "remote k");
    rdchk(`UHP_OFS_PORT, FPR, FPR, "remote fpr");
    rdchk(`UHP_OFS_STS, PCD, PCD, "remote pcd");
    chk(32'(irq), 32'h1, "remote irq");
    xfer(1'b1, `UHP_OFS_STS, PCD | PME);
    end_resume();
  endtask
  task automatic t_disc;
    // disable the port while it is suspended, then send resume k
    suspend();
    xfer(1'b1, `UHP_OFS_PORT, BASE);
    remote_k();
    chk(32'(drive_resume_k), 32'h0, "dis no k");
    chk(32'(port_suspended), 32'h1, "dis stays");
    rdchk(`UHP_OFS_PORT, FPR | PE, 32'h0, "dis port");
    rdchk(`UHP_OFS_STS, PCD | PME, 32'h0, "dis pcd");
    @(posedge pclk);
    attach <= 1'b0;
    tick(10);
    rdchk(`UHP_OFS_PORT, 32'h7, CSC, "disc bits");
    rdchk(`UHP_OFS_STS, PCD, PCD, "disc pcd");
    chk(32'(power_mgmt_event_n), 32'h1, "disc no wake");
    xfer(1'b1, `UHP_OFS_STS, PCD | PME);
    xfer(1'b1, `UHP_OFS_PORT, PWR | WDC | CSC);
    @(posedge pclk);
    attach <= 1'b1;
    tick(10);
    rdchk(`UHP_OFS_STS, PCD, PCD, "conn2 pcd");
    chk(32'(power_mgmt_event_n), 32'h1, "conn2 no wake");
    @(posedge pclk);
    attach <= 1'b0;
    tick(10);
    chk(32'(power_mgmt_event_n), 32'h0, "disc2 wake");
    // wake feature off: enabled disconnect still sets status only
    xfer(1'b1, `UHP_OFS_STS, PCD | PME);
    xfer(1'b1, `UHP_OFS_CFG, 32'h1);
    @(posedge pclk);
    attach <= 1'b1;
    tick(10);
    @(posedge pclk);
    attach <= 1'b0;
    tick(10);
    rdchk(`UHP_OFS_STS, PME, PME, "disc3 sts");
    chk(32'(power_mgmt_event_n), 32'h1, "disc3 no feat");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    frame_boundary = 1'b0;
    controller_halted = 1'b1;
    attach = 1'b0;
    wake_req = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_power();
    t_connect();
    t_sw_resume();
    t_remote();
    t_disc();
    stop_test();
  end
  // whole run is about a thousand cycles; this allows ample margin
  initial begin
    #100000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
